// ==== rtl/wwd_cfg.svh ====
// Register offsets, field positions, reset values and counts of the watchdog
`ifndef WWD_CFG_SVH
`define WWD_CFG_SVH
`define WWD_OFF_MODE      8'h00
`define WWD_OFF_TCONST    8'h04
`define WWD_OFF_FEED      8'h08
`define WWD_OFF_COUNT     8'h0C
`define WWD_OFF_CLKSEL    8'h10
`define WWD_OFF_WARN      8'h14
`define WWD_OFF_WINDOW    8'h18
`define WWD_OFF_STAT      8'h1C
`define WWD_OFF_MASK      8'h20
`define WWD_MODE_EN       0
`define WWD_MODE_RSTMODE  1
`define WWD_MODE_RSTFLAG  2
`define WWD_MODE_WINEN    3
`define WWD_CLK_SRC       0
`define WWD_CLK_CPU       8
`define WWD_CLK_FRQ_LSB   4
`define WWD_ST_TIMEOUT    0
`define WWD_ST_WARN       1
`define WWD_ST_FEEDERR    2
`define WWD_FEED_FIRST    8'hAA
`define WWD_FEED_SECOND   8'h55
`define WWD_TC_MIN        24'h0000FF
`define WWD_TC_RESET      24'h0000FF
`define WWD_WIN_RESET     24'hFFFFFF
`define WWD_WARN_RESET    10'h000
`define WWD_FRQ_RESET     4'h0
`define WWD_RST_CYCLES    4'hF
`endif

// ==== rtl/wwd_pkg.sv ====
// Types shared by the windowed watchdog
package wwd_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } wwd_apb_req_t;

    typedef enum logic [1:0] {
        WWD_IDLE  = 2'b00,
        WWD_ARMED = 2'b01,
        WWD_RUN   = 2'b11
    } wwd_state_t;
endpackage

// ==== rtl/wwd_top.sv ====
// Windowed watchdog with APB registers, tick selection and fault response
// How it works
// [R1] Running watchdog reaching zero without valid reload forces a chip reset, or interrupt in interrupt mode.
// [R2] With window enabled, a feed in the run state while count above window is a violation.
// [R3] Warning flag raised when the count equals the programmed warning value.
// [R4] Enable is set-only; cleared by reset or by a fault response.
// [R5] Bad feed sequence gives chip reset, or interrupt in interrupt mode.
// [R6] A readable flag records that the watchdog forced a chip reset.
// [R7] 24-bit down counter, tick divided by four, minimum constant 256 counts.
// [R8] Tick source selectable between internal RC and dedicated oscillator.
// [R9] Oscillator frequency code and CPU clock selection driven as outputs.
// [R10] Software must feed periodically inside the window to avoid reset.
// [R11] Feed is AA then 55 back to back; only the pair reloads and starts the count.
`include "wwd_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module wwd_top #(
    parameter int CW = 24,
    parameter int WW = 10
) (
    input  wire logic                 clk_in,
    input  wire logic                 resetn_in,
    input  wire wwd_pkg::wwd_apb_req_t apb_in,
    input  wire logic                 irc_tick_in,
    input  wire logic                 wdo_tick_in,
    output logic [31:0]               prdata_out,
    output logic                      pready_out,
    output logic                      pslverr_out,
    output logic                      irq_out,
    output logic                      chip_reset_out,
    output logic [3:0]                osc_freq_out,
    output logic                      cpu_clk_sel_out
);
    import wwd_pkg::*;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `WWD_OFF_MODE)   || (a == `WWD_OFF_TCONST) ||
                    (a == `WWD_OFF_FEED)   || (a == `WWD_OFF_COUNT)  ||
                    (a == `WWD_OFF_CLKSEL) || (a == `WWD_OFF_WARN)   ||
                    (a == `WWD_OFF_WINDOW) || (a == `WWD_OFF_STAT)   ||
                    (a == `WWD_OFF_MASK);
    endfunction

    // Two-stage sync plus a third stage for edge detection
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] sync3;
    logic [1:0] raw_tick;
    assign raw_tick = {wdo_tick_in, irc_tick_in};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    sync1[g] <= 1'b0;
                    sync2[g] <= 1'b0;
                    sync3[g] <= 1'b0;
                end else begin
                    sync1[g] <= raw_tick[g];
                    sync2[g] <= sync1[g];
                    sync3[g] <= sync2[g];
                end
            end
        end
    endgenerate

    wwd_state_t    state;
    wwd_state_t    next_state;
    logic          en;
    logic          next_en;
    logic          rst_mode;
    logic          next_rst_mode;
    logic          rst_flag;
    logic          next_rst_flag;
    logic          win_en;
    logic          next_win_en;
    logic [CW-1:0] tconst;
    logic [CW-1:0] next_tconst;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic [CW-1:0] window;
    logic [CW-1:0] next_window;
    logic [WW-1:0] warn;
    logic [WW-1:0] next_warn;
    logic          clk_src;
    logic          next_clk_src;
    logic [3:0]    next_osc_freq;
    logic          next_cpu_sel;
    logic [2:0]    stat;
    logic [2:0]    next_stat;
    logic [2:0]    mask;
    logic [2:0]    next_mask;
    logic [1:0]    presc;
    logic [1:0]    next_presc;
    logic          feed_half;
    logic          next_feed_half;
    logic [3:0]    rst_cnt;
    logic [3:0]    next_rst_cnt;
    logic [31:0]   next_prdata;
    logic          next_pready;
    logic          next_pslverr;
    logic          next_irq;

    logic          setup;
    logic          access;
    logic          wr;
    logic          rd;
    logic          tick;
    logic          tick4;
    logic          feed_wr;
    logic          good_feed;
    logic          feed_err;
    logic          win_viol;
    logic          timeout;
    logic          fault;
    logic [2:0]    set_bits;
    logic [2:0]    clr_bits;
    logic [31:0]   rmux;

    always_comb begin
        setup  = apb_in.psel && !apb_in.penable;
        access = apb_in.psel && apb_in.penable && pready_out;
        wr     = access && apb_in.pwrite;
        rd     = access && !apb_in.pwrite;

        // Selected source, one pulse per rising edge
        tick  = clk_src ? (sync2[1] && !sync3[1])
                        : (sync2[0] && !sync3[0]); // [R8]
        tick4 = tick && (presc == 2'h3); // [R7]
        next_presc = tick ? presc + 2'h1 : presc; // [R7]

        // Pair must be back to back: any other access breaks it
        feed_wr   = wr && (apb_in.paddr == `WWD_OFF_FEED);
        good_feed = feed_wr && feed_half &&
                    (apb_in.pwdata[7:0] == `WWD_FEED_SECOND); // [R11]
        feed_err  = access && en && !good_feed &&
                    (feed_half || (feed_wr &&
                     apb_in.pwdata[7:0] != `WWD_FEED_FIRST)); // [R5]
        next_feed_half = feed_half;
        if (access) begin
            next_feed_half = feed_wr && !feed_half &&
                (apb_in.pwdata[7:0] == `WWD_FEED_FIRST); // [R11]
        end

        win_viol = good_feed && win_en && (state == WWD_RUN) &&
                   (count > window); // [R2]
        timeout  = (state == WWD_RUN) && tick4 &&
                   (count == '0) && !good_feed; // [R1]
        fault    = timeout || feed_err || win_viol;

        next_state    = state;
        next_en       = en;
        next_count    = count;
        next_rst_cnt  = (rst_cnt != 4'h0) ? rst_cnt - 4'h1 : rst_cnt;
        next_rst_flag = rst_flag;
        set_bits      = 3'h0;
        clr_bits      = 3'h0;

        if (state == WWD_RUN && tick4 && count != '0) begin
            next_count = count - 1'b1; // [R7]
            if (count - 1'b1 == {{(CW-WW){1'b0}}, warn}) begin
                set_bits[`WWD_ST_WARN] = 1'b1; // [R3]
            end
        end

        if (good_feed && !win_viol) begin
            next_count = tconst; // [R11]
            if (en) begin
                next_state = WWD_RUN; // [R11]
            end
        end

        if (timeout) begin
            set_bits[`WWD_ST_TIMEOUT] = 1'b1; // [R1]
        end
        if (feed_err || win_viol) begin
            set_bits[`WWD_ST_FEEDERR] = 1'b1; // [R5]
        end

        // Software writes, then fault response so it overrides enable
        next_rst_mode = rst_mode;
        next_win_en   = win_en;
        next_tconst   = tconst;
        next_window   = window;
        next_warn     = warn;
        next_clk_src  = clk_src;
        next_osc_freq = osc_freq_out;
        next_cpu_sel  = cpu_clk_sel_out;
        next_mask     = mask;
        if (wr) begin
            unique case (apb_in.paddr)
                `WWD_OFF_MODE: begin
                    if (apb_in.pwdata[`WWD_MODE_EN]) begin
                        next_en = 1'b1; // [R4]
                        if (state == WWD_IDLE) begin
                            next_state = WWD_ARMED;
                        end
                    end
                    next_rst_mode = apb_in.pwdata[`WWD_MODE_RSTMODE];
                    next_win_en   = apb_in.pwdata[`WWD_MODE_WINEN];
                    if (apb_in.pwdata[`WWD_MODE_RSTFLAG]) begin
                        next_rst_flag = 1'b0;
                    end
                end
                `WWD_OFF_TCONST: begin
                    // Below the minimum would break the 256-count floor
                    next_tconst = (apb_in.pwdata[CW-1:0] < `WWD_TC_MIN) ?
                        `WWD_TC_MIN : apb_in.pwdata[CW-1:0]; // [R7]
                end
                `WWD_OFF_CLKSEL: begin
                    next_clk_src  = apb_in.pwdata[`WWD_CLK_SRC]; // [R8]
                    next_cpu_sel  = apb_in.pwdata[`WWD_CLK_CPU]; // [R9]
                    next_osc_freq =
                        apb_in.pwdata[`WWD_CLK_FRQ_LSB +: 4]; // [R9]
                end
                `WWD_OFF_WARN:   next_warn   = apb_in.pwdata[WW-1:0];
                `WWD_OFF_WINDOW: next_window = apb_in.pwdata[CW-1:0];
                `WWD_OFF_MASK:   next_mask   = apb_in.pwdata[2:0];
                default: ;
            endcase
        end
        if (rd && apb_in.paddr == `WWD_OFF_STAT) begin
            clr_bits = 3'h7;
        end

        if (fault) begin
            next_en    = 1'b0; // [R4]
            next_state = WWD_IDLE; // [R4]
            if (rst_mode) begin
                next_rst_cnt  = `WWD_RST_CYCLES; // [R1] [R5]
                next_rst_flag = 1'b1; // [R6]
            end
        end

        // Set wins over read-clear
        next_stat = (stat & ~clr_bits) | set_bits;
        next_irq  = |(next_stat & next_mask);

        rmux = 32'h0000_0000;
        unique case (apb_in.paddr)
            `WWD_OFF_MODE: begin
                rmux[`WWD_MODE_EN]      = en;
                rmux[`WWD_MODE_RSTMODE] = rst_mode;
                rmux[`WWD_MODE_RSTFLAG] = rst_flag; // [R6]
                rmux[`WWD_MODE_WINEN]   = win_en;
            end
            `WWD_OFF_TCONST: rmux[CW-1:0] = tconst;
            `WWD_OFF_COUNT:  rmux[CW-1:0] = count;
            `WWD_OFF_CLKSEL: begin
                rmux[`WWD_CLK_SRC]          = clk_src;
                rmux[`WWD_CLK_CPU]          = cpu_clk_sel_out;
                rmux[`WWD_CLK_FRQ_LSB +: 4] = osc_freq_out;
            end
            `WWD_OFF_WARN:   rmux[WW-1:0] = warn;
            `WWD_OFF_WINDOW: rmux[CW-1:0] = window;
            `WWD_OFF_STAT:   rmux[2:0]    = stat;
            `WWD_OFF_MASK:   rmux[2:0]    = mask;
            default: ;
        endcase
        // Data captured in setup so the answer comes one cycle later
        next_pready  = setup;
        next_pslverr = setup && !is_mapped(apb_in.paddr);
        next_prdata  = (setup && !apb_in.pwrite) ? rmux : 32'h0000_0000;
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state           <= WWD_IDLE;
            en              <= 1'b0;
            rst_mode        <= 1'b0;
            rst_flag        <= 1'b0;
            win_en          <= 1'b0;
            tconst          <= `WWD_TC_RESET;
            count           <= `WWD_TC_RESET;
            window          <= `WWD_WIN_RESET;
            warn            <= `WWD_WARN_RESET;
            clk_src         <= 1'b0;
            osc_freq_out    <= `WWD_FRQ_RESET;
            cpu_clk_sel_out <= 1'b0;
            stat            <= 3'h0;
            mask            <= 3'h0;
            presc           <= 2'h0;
            feed_half       <= 1'b0;
            rst_cnt         <= 4'h0;
            chip_reset_out  <= 1'b0;
            irq_out         <= 1'b0;
            prdata_out      <= 32'h0000_0000;
            pready_out      <= 1'b0;
            pslverr_out     <= 1'b0;
        end else begin
            state           <= next_state;
            en              <= next_en;
            rst_mode        <= next_rst_mode;
            rst_flag        <= next_rst_flag;
            win_en          <= next_win_en;
            tconst          <= next_tconst;
            count           <= next_count;
            window          <= next_window;
            warn            <= next_warn;
            clk_src         <= next_clk_src;
            osc_freq_out    <= next_osc_freq;
            cpu_clk_sel_out <= next_cpu_sel;
            stat            <= next_stat;
            mask            <= next_mask;
            presc           <= next_presc;
            feed_half       <= next_feed_half;
            rst_cnt         <= next_rst_cnt;
            chip_reset_out  <= (next_rst_cnt != 4'h0); // [R1]
            irq_out         <= next_irq;
            prdata_out      <= next_prdata;
            pready_out      <= next_pready;
            pslverr_out     <= next_pslverr;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the windowed watchdog
`include "wwd_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import wwd_pkg::*;
    typedef struct {
        logic        wr;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] q;
        logic        e;
    } wwd_row_t;
    logic         clk_in;
    logic         resetn_in;
    logic         irc_tick_in;
    logic         wdo_tick_in;
    wwd_apb_req_t apb_in;
    logic [31:0]  prdata_out;
    logic         pready_out;
    logic         pslverr_out;
    logic         irq_out;
    logic         chip_reset_out;
    logic [3:0]   osc_freq_out;
    logic         cpu_clk_sel_out;
    logic [3:0]   tick_div = 4'h0;
    logic [31:0]  rd;
    logic         err;
    int           failures = 0;
    int           checked = 0;
    int           n;
    wwd_row_t rows [14] = '{
        '{1'h0, `WWD_OFF_MODE,   32'h0, 32'h0, 1'h0},
        '{1'h0, `WWD_OFF_TCONST, 32'h0, 32'hFF, 1'h0},
        '{1'h0, `WWD_OFF_WINDOW, 32'h0, 32'hFFFFFF, 1'h0},
        '{1'h0, `WWD_OFF_WARN,   32'h0, 32'h0, 1'h0},
        '{1'h0, `WWD_OFF_CLKSEL, 32'h0, 32'h0, 1'h0},
        '{1'h0, `WWD_OFF_STAT,   32'h0, 32'h0, 1'h0},
        '{1'h0, `WWD_OFF_MASK,   32'h0, 32'h0, 1'h0},
        '{1'h1, `WWD_OFF_TCONST, 32'hFFFFFFFF, 32'hFFFFFF, 1'h0},
        '{1'h1, `WWD_OFF_TCONST, 32'h10, 32'hFF, 1'h0},
        '{1'h1, `WWD_OFF_WARN,   32'hFFFFFFFF, 32'h3FF, 1'h0},
        '{1'h1, `WWD_OFF_CLKSEL, 32'hFFFFFFFF, 32'h1F1, 1'h0},
        '{1'h1, `WWD_OFF_MASK,   32'hFFFFFFFF, 32'h7, 1'h0},
        '{1'h1, `WWD_OFF_WINDOW, 32'h10, 32'h10, 1'h0},
        '{1'h1, 8'h40, 32'h1234, 32'h0, 1'h1}};
    wwd_top uut (.clk_in, .resetn_in, .apb_in, .irc_tick_in, .wdo_tick_in,
        .prdata_out, .pready_out, .pslverr_out, .irq_out, .chip_reset_out,
        .osc_freq_out, .cpu_clk_sel_out);
    // Ticks well below half the bus clock so the synchroniser sees them
    assign irc_tick_in = tick_div[2];
    assign wdo_tick_in = tick_div[1];
    always @(posedge clk_in) begin
        tick_div <= tick_div + 4'h1;
    end
    initial begin
        clk_in = 1'h0;
        forever #5 clk_in = ~clk_in;
    end
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_in);
        apb_in <= '{1'h1, 1'h0, w, a, d};
        @(posedge clk_in);
        apb_in.penable <= 1'h1;
        do begin
            @(posedge clk_in);
            k++;
        end while (pready_out !== 1'h1 && k < 20);
        // A bus that never answers counts against the run
        if (pready_out !== 1'h1) failures++;
        rd = prdata_out;
        err = pslverr_out;
        apb_in <= '0;
    endtask
    task automatic feed();
        apb(1'h1, `WWD_OFF_FEED, 32'hAA);
        apb(1'h1, `WWD_OFF_FEED, 32'h55);
    endtask
    task automatic end_of_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #300us;
        failures++;
        end_of_test();
    end
    initial begin
        resetn_in = 1'h0;
        apb_in = '0;
        repeat (4) @(posedge clk_in);
        resetn_in <= 1'h1;
        foreach (rows[i]) begin
            if (rows[i].wr) apb(1'h1, rows[i].a, rows[i].d);
            apb(1'h0, rows[i].a, 32'h0);
            chk("rdata", rd, rows[i].q);
            chk("slverr", err, rows[i].e);
        end
        chk("osc", osc_freq_out, 4'hF);
        chk("cpusel", cpu_clk_sel_out, 1'h1);
        // Timeout run on the faster tick source
        apb(1'h1, `WWD_OFF_TCONST, 32'h100);
        apb(1'h1, `WWD_OFF_WARN, 32'hF8);
        apb(1'h1, `WWD_OFF_CLKSEL, 32'h1);
        apb(1'h1, `WWD_OFF_MODE, 32'h3);
        // Enable written low, reset mode kept
        apb(1'h1, `WWD_OFF_MODE, 32'h2);
        apb(1'h0, `WWD_OFF_MODE, 32'h0);
        chk("mode", rd, 32'h3);
        feed();
        apb(1'h0, `WWD_OFF_COUNT, 32'h0);
        chk("count", rd >= 32'hFE && rd <= 32'h100, 1'h1);
        n = 0;
        while (irq_out !== 1'h1 && n < 400) begin
            @(posedge clk_in);
            n++;
        end
        chk("irqup", irq_out, 1'h1);
        apb(1'h0, `WWD_OFF_STAT, 32'h0);
        chk("stat", rd, 32'h2);
        repeat (2) @(posedge clk_in);
        chk("irq", irq_out, 1'h0);
        n = 0;
        while (chip_reset_out !== 1'h1 && n < 6000) begin
            @(posedge clk_in);
            n++;
        end
        chk("rstup", chip_reset_out, 1'h1);
        n = 0;
        while (chip_reset_out === 1'h1 && n < 40) begin
            @(posedge clk_in);
            n++;
        end
        chk("rstlen", n, 32'hF);
        apb(1'h0, `WWD_OFF_STAT, 32'h0);
        chk("stat", rd, 32'h1);
        apb(1'h0, `WWD_OFF_MODE, 32'h0);
        chk("mode", rd, 32'h6);
        // Broken feed in interrupt mode
        apb(1'h1, `WWD_OFF_MODE, 32'h5);
        apb(1'h0, `WWD_OFF_MODE, 32'h0);
        chk("mode", rd, 32'h1);
        apb(1'h1, `WWD_OFF_FEED, 32'hAA);
        apb(1'h0, `WWD_OFF_COUNT, 32'h0);
        repeat (2) @(posedge clk_in);
        chk("irq", irq_out, 1'h1);
        chk("chiprst", chip_reset_out, 1'h0);
        apb(1'h0, `WWD_OFF_STAT, 32'h0);
        chk("stat", rd, 32'h4);
        apb(1'h0, `WWD_OFF_MODE, 32'h0);
        chk("mode", rd, 32'h0);
        // Early feed with window on, interrupt masked
        apb(1'h1, `WWD_OFF_MASK, 32'h0);
        apb(1'h1, `WWD_OFF_MODE, 32'h9);
        feed();
        feed();
        repeat (2) @(posedge clk_in);
        chk("irq", irq_out, 1'h0);
        apb(1'h0, `WWD_OFF_STAT, 32'h0);
        chk("stat", rd, 32'h4);
        apb(1'h0, `WWD_OFF_MODE, 32'h0);
        chk("mode", rd, 32'h8);
        // Feed inside the window, slower tick source
        apb(1'h1, `WWD_OFF_WINDOW, 32'h100);
        apb(1'h1, `WWD_OFF_CLKSEL, 32'h0);
        apb(1'h1, `WWD_OFF_MODE, 32'h9);
        feed();
        feed();
        // 161 edges hold five or six prescaled ticks
        repeat (160) @(posedge clk_in);
        apb(1'h0, `WWD_OFF_COUNT, 32'h0);
        chk("irccount", rd >= 32'hFA && rd <= 32'hFB, 1'h1);
        apb(1'h0, `WWD_OFF_STAT, 32'h0);
        chk("stat", rd, 32'h0);
        apb(1'h0, `WWD_OFF_MODE, 32'h0);
        chk("mode", rd, 32'h9);
        // Hardware reset in mid-run drops the enable
        apb(1'h1, `WWD_OFF_MODE, 32'h1);
        feed();
        resetn_in <= 1'h0;
        @(posedge clk_in);
        resetn_in <= 1'h1;
        apb(1'h0, `WWD_OFF_MODE, 32'h0);
        chk("mode", rd, 32'h0);
        apb(1'h0, `WWD_OFF_TCONST, 32'h0);
        chk("tconst", rd, 32'hFF);
        chk("chiprst", chip_reset_out, 1'h0);
        end_of_test();
    end
endmodule
`default_nettype wire

// ==== testbench/wwd_properties.sv ====
// Port-level assertions for the windowed watchdog
`include "wwd_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module wwd_properties (
    input wire logic                  clk_in,
    input wire logic                  resetn_in,
    input wire wwd_pkg::wwd_apb_req_t apb_in,
    input wire logic [31:0]           prdata_out,
    input wire logic                  pready_out,
    input wire logic                  pslverr_out,
    input wire logic                  irq_out,
    input wire logic                  chip_reset_out,
    input wire logic [3:0]            osc_freq_out,
    input wire logic                  cpu_clk_sel_out
);
    import wwd_pkg::*;
    logic [4:0] hi_len;
    logic [4:0] next_hi_len;
    logic       clk_wr;
    // Counts how long the chip reset stays high
    assign clk_wr = pready_out && apb_in.psel && apb_in.pwrite
                    && apb_in.paddr == `WWD_OFF_CLKSEL;
    always_comb begin
        next_hi_len = chip_reset_out ? hi_len + 5'h1 : 5'h0;
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hi_len <= 5'h0;
        end else begin
            hi_len <= next_hi_len;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_setup;
        apb_in.psel && !apb_in.penable;
    endsequence
    sequence s_clk_wr;
        $past(clk_wr) || $past(clk_wr, 2);
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready_out)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property (pready_out |->
        pslverr_out == (apb_in.paddr > `WWD_OFF_MASK ||
                        apb_in.paddr[1:0] != 2'h0))
        else $error("slave error on wrong address");
    a_data_idle_zero: assert property (!pready_out |-> prdata_out == '0)
        else $error("read data outside access");
    a_reset_len: assert property (!chip_reset_out && hi_len != 0 |->
        hi_len == 5'hF) else $error("chip reset length wrong");
    a_osc_by_write: assert property (
        !$stable(osc_freq_out) |-> s_clk_wr)
        else $error("oscillator code changed unasked");
    a_cpu_by_write: assert property (
        !$stable(cpu_clk_sel_out) |-> s_clk_wr)
        else $error("cpu clock select changed unasked");
    a_irq_clear: assert property (
        $fell(irq_out) |-> $past(pready_out) || $past(pready_out, 2))
        else $error("interrupt dropped without access");
endmodule
bind wwd_top wwd_properties u_chk (.clk_in, .resetn_in, .apb_in,
    .prdata_out, .pready_out, .pslverr_out, .irq_out, .chip_reset_out,
    .osc_freq_out, .cpu_clk_sel_out);
`default_nettype wire
